// ===== inc/pf_seq_pkg.sv
package pf_seq_pkg;

  // ------------------------------------------------------------------
  // supply levels and interval codes
  // ------------------------------------------------------------------
  // comparator outputs, all synchronous to clk_i
  typedef struct packed {
    logic above_poweron;
    logic above_reset;
    logic above_warning;
  } supply_t;

  // periodic interval select
  localparam logic [1:0] IVL_CONT = 2'h0;
  localparam logic [1:0] IVL_2E11 = 2'h1;
  localparam logic [1:0] IVL_2E12 = 2'h2;
  localparam logic [1:0] IVL_2E13 = 2'h3;
  localparam int IVL_EXP_11 = 11;
  localparam int IVL_EXP_12 = 12;
  localparam int IVL_EXP_13 = 13;
  localparam int TICK_CNT_W = 14;

  // detection window and confirmation, in ring-oscillator ticks
  localparam logic [1:0] DETECT_TICKS = 2'h2;
  localparam logic [1:0] CONFIRM_TICKS = 2'h1;

  // reset values
  localparam logic MONITOR_DISABLE_RST = 1'b1;
  localparam logic [15:0] RESUME_ADDR = 16'h8000;

  // cycles a supply drop must persist to qualify
  localparam int QUALIFY_CYCLES = 4;

  // ------------------------------------------------------------------
  // sequencer states (gray along run -> stop -> wake; wake -> run changes two bits)
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_STOP   = 3'b001,
    ST_WARMUP = 3'b011,
    ST_PFRST  = 3'b010,
    ST_PORRST = 3'b110
  } seq_state_t;

endpackage

// ===== logic/pf_periodic_timer.sv
`timescale 1ns/100ps
`default_nettype none
module pf_periodic_timer
  import pf_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic ring_tick_i,
  input wire logic [1:0] interval_i,
  output logic window_o,
  output logic window_end_o
);

  // ------------------------------------------------------------------
  // interval counter
  // ------------------------------------------------------------------
  function automatic logic [TICK_CNT_W-1:0] limit(input logic [1:0] sel);
    case (sel)
      IVL_2E11: limit = TICK_CNT_W'(1 << IVL_EXP_11);
      IVL_2E12: limit = TICK_CNT_W'(1 << IVL_EXP_12);
      IVL_2E13: limit = TICK_CNT_W'(1 << IVL_EXP_13);
      default: limit = '0;
    endcase
  endfunction

  logic [TICK_CNT_W-1:0] cnt_reg;
  logic [1:0] win_reg;
  logic cont;

  assign cont = (interval_i == IVL_CONT);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else if (!run_i || cont || win_reg != 2'h0) begin
      cnt_reg <= '0;
    end else if (ring_tick_i) begin
      if (cnt_reg >= limit(interval_i) - TICK_CNT_W'(1)) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + TICK_CNT_W'(1);
      end
    end
  end

  // window stays open for the detect ticks after each interval
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      win_reg <= 2'h0;
    end else if (!run_i) begin
      win_reg <= 2'h0;
    end else if (ring_tick_i) begin
      if (win_reg != 2'h0) begin
        win_reg <= win_reg - 2'h1;
      end else if (!cont &&
                   cnt_reg >= limit(interval_i) - TICK_CNT_W'(1)) begin
        win_reg <= DETECT_TICKS;
      end
    end
  end

  assign window_o = run_i && (cont || win_reg != 2'h0);
  assign window_end_o = run_i && ring_tick_i &&
                        (cont || win_reg == 2'h1);

endmodule
`default_nettype wire

// ===== logic/stop_mode_power_fail_sequencer.sv
// Functional notes
// R1 - short drop: no fail, stay stopped
// R2 - warning in stop: power up, warm, exit
// R3 - reset level: cpu reset, power off, periodic
// R4 - below poweron: all reset, everything off
// R5 - monitor disabled: monitor, regulator, crystal off
// R6 - wake enables monitor; warning sets fail flag
// R7 - vector to higher priority source
// R8 - wake at reset level: cpu reset, periodic
// R9 - disable bit resets to one, blocks detection
// R10 - interval continuous or 2^11/12/13 ticks
// R11 - two-tick check, one more confirm period
// R12 - release resumes at 8000h after warmup
// R13 - synced comparators, crystal ready gates exits
`timescale 1ns/100ps
`default_nettype none
module stop_mode_power_fail_sequencer
  import pf_seq_pkg::*;
#(
  parameter int QUAL_CYCLES = QUALIFY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire supply_t supply_i,
  input wire logic stop_req_i,
  input wire logic wake_irq_i,
  input wire logic wake_irq_hi_prio_i,
  input wire logic monitor_disable_wr_i,
  input wire logic monitor_disable_i,
  input wire logic [1:0] interval_i,
  input wire logic ring_tick_i,
  input wire logic crystal_ready_i,
  input wire logic pf_flag_clr_i,
  output logic cpu_stopped_o,
  output logic cpu_reset_o,
  output logic regulator_en_o,
  output logic crystal_en_o,
  output logic monitor_en_o,
  output logic sram_retain_o,
  output logic pf_flag_o,
  output logic stop_exit_o,
  output logic vector_pf_o,
  output logic resume_valid_o,
  output logic [15:0] resume_addr_o,
  output logic stop_monitor_disable_o
);

  // ------------------------------------------------------------------
  // control bit and qualification
  // ------------------------------------------------------------------
  seq_state_t state_reg;
  logic dis_reg;
  logic [7:0] qual_reg;
  logic warn_q, rstlvl_q;
  logic [1:0] conf_reg;
  logic mon_on, win;

  // R9 disable defaults set
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dis_reg <= MONITOR_DISABLE_RST;
    end else if (monitor_disable_wr_i) begin
      dis_reg <= monitor_disable_i;
    end
  end

  // R1 drops shorter than the qualify time are ignored
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      qual_reg <= 8'h0;
    end else if (!mon_on || supply_i.above_warning) begin
      qual_reg <= 8'h0;
    end else if (qual_reg < 8'(QUAL_CYCLES)) begin
      qual_reg <= qual_reg + 8'h1;
    end
  end

  // R13 comparators used as synced levels
  assign warn_q = (qual_reg >= 8'(QUAL_CYCLES)) && supply_i.above_reset;
  assign rstlvl_q = (qual_reg >= 8'(QUAL_CYCLES)) && !supply_i.above_reset;

  // ------------------------------------------------------------------
  // periodic monitor
  // ------------------------------------------------------------------
  // R10 interval select
  pf_periodic_timer u_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .run_i(state_reg == ST_PFRST),
    .ring_tick_i(ring_tick_i),
    .interval_i(interval_i),
    .window_o(win),
    .window_end_o()
  );

  // R5 monitor off in stop when disabled, R4 off below poweron
  always_comb begin
    case (state_reg)
      ST_STOP: mon_on = !dis_reg;
      // R11 stays on for the confirm tick after a good window
      ST_PFRST: mon_on = win || (conf_reg == DETECT_TICKS);
      ST_PORRST: mon_on = 1'b0;
      default: mon_on = 1'b1;
    endcase
  end

  // R11 two detect ticks, then one confirm tick, all above reset
  // a partial window starts over, so it never carries into the next one
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conf_reg <= 2'h0;
    end else if (state_reg != ST_PFRST || !mon_on ||
                 !supply_i.above_reset) begin
      conf_reg <= 2'h0;
    end else if (ring_tick_i &&
                 conf_reg != DETECT_TICKS + CONFIRM_TICKS) begin
      conf_reg <= conf_reg + 2'h1;
    end
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_PORRST;
    end else if (!supply_i.above_poweron) begin
      // R4 hold everything in reset
      state_reg <= ST_PORRST;
    end else begin
      case (state_reg)
        ST_PORRST: state_reg <= ST_WARMUP;
        ST_RUN: begin
          if (rstlvl_q) begin
            state_reg <= ST_PFRST;
          end else if (stop_req_i) begin
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          // R3 R8 reset level found by monitor
          if (rstlvl_q) begin
            state_reg <= ST_PFRST;
          // R2 R6 warning or wake powers up
          end else if (warn_q || wake_irq_i) begin
            state_reg <= ST_WARMUP;
          end
        end
        ST_WARMUP: begin
          // R13 crystal ready gates the exit
          if (rstlvl_q) begin
            state_reg <= ST_PFRST;
          end else if (crystal_ready_i) begin
            state_reg <= ST_RUN;
          end
        end
        ST_PFRST: begin
          if (conf_reg == DETECT_TICKS + CONFIRM_TICKS) begin
            state_reg <= ST_WARMUP;
          end
        end
        default: state_reg <= ST_PORRST;
      endcase
    end
  end

  // R6 flag set wins over clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pf_flag_o <= 1'b0;
    end else if (warn_q && state_reg != ST_PORRST) begin
      pf_flag_o <= 1'b1;
    end else if (pf_flag_clr_i) begin
      pf_flag_o <= 1'b0;
    end
  end

  // remembers a warm-up after power-fail or poweron reset for the resume vector
  logic from_rst_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      from_rst_reg <= 1'b1;
    end else if (state_reg == ST_PFRST || state_reg == ST_PORRST) begin
      from_rst_reg <= 1'b1;
    end else if (state_reg == ST_RUN) begin
      from_rst_reg <= 1'b0;
    end
  end

  logic exiting;
  assign exiting = (state_reg == ST_WARMUP) && crystal_ready_i &&
                   !rstlvl_q && supply_i.above_poweron;

  // R12 resume address, R7 vector choice
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_exit_o <= 1'b0;
      resume_valid_o <= 1'b0;
      vector_pf_o <= 1'b0;
      resume_addr_o <= 16'h0;
    end else begin
      stop_exit_o <= exiting && !from_rst_reg;
      resume_valid_o <= exiting && from_rst_reg;
      resume_addr_o <= RESUME_ADDR;
      if (exiting && !from_rst_reg) begin
        // R7 higher priority wins
        vector_pf_o <= pf_flag_o && !(wake_irq_hi_prio_i && wake_irq_i);
      end
    end
  end

  // ------------------------------------------------------------------
  // power outputs
  // ------------------------------------------------------------------
  // R3 R5 regulator and crystal only in run and warm-up
  assign regulator_en_o = (state_reg == ST_RUN) || (state_reg == ST_WARMUP);
  assign crystal_en_o = regulator_en_o;
  assign monitor_en_o = mon_on;
  assign cpu_stopped_o = (state_reg == ST_STOP);
  assign cpu_reset_o = (state_reg == ST_PFRST) || (state_reg == ST_PORRST)
                       || (state_reg == ST_WARMUP && from_rst_reg);
  assign sram_retain_o = (state_reg != ST_PORRST);
  assign stop_monitor_disable_o = dis_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_POR_OFF: assert property (@(posedge clk_i) // R4
    disable iff (!rstn_i)
    !supply_i.above_poweron |=> !regulator_en_o && !monitor_en_o)
    else $error("power not off below poweron");
  AST_DIS_OFF: assert property (@(posedge clk_i) // R5
    disable iff (!rstn_i)
    cpu_stopped_o && stop_monitor_disable_o |-> !monitor_en_o)
    else $error("monitor on while disabled in stop");
  AST_SHORT_DROP: assert property (@(posedge clk_i) // R1
    disable iff (!rstn_i)
    cpu_stopped_o && !stop_monitor_disable_o && supply_i.above_warning
    ##1 !supply_i.above_warning |=> !pf_flag_o || $past(pf_flag_o))
    else $error("short drop reported");
  AST_RST_LVL: assert property (@(posedge clk_i) // R3
    disable iff (!rstn_i)
    state_reg == ST_PFRST |-> cpu_reset_o && !crystal_en_o && sram_retain_o)
    else $error("power-fail reset outputs wrong");
  AST_STOP_RST: assert property (@(posedge clk_i) // R3
    disable iff (!rstn_i)
    cpu_stopped_o && rstlvl_q && supply_i.above_poweron |=>
      cpu_reset_o && !regulator_en_o && !crystal_en_o && sram_retain_o)
    else $error("reset level in stop not handled");
  AST_WAKE: assert property (@(posedge clk_i) // R6
    disable iff (!rstn_i)
    cpu_stopped_o && wake_irq_i && supply_i.above_reset
    && supply_i.above_poweron |=> regulator_en_o)
    else $error("wake did not power up");
  AST_EXIT_GATE: assert property (@(posedge clk_i) // R13
    disable iff (!rstn_i)
    $rose(stop_exit_o) |-> $past(crystal_ready_i))
    else $error("exit without crystal ready");
  AST_RESUME: assert property (@(posedge clk_i) // R12
    disable iff (!rstn_i)
    resume_valid_o |-> resume_addr_o == 16'h8000)
    else $error("resume address wrong");
  AST_DIS_RST: assert property (@(posedge clk_i) // R9
    $rose(rstn_i) |-> stop_monitor_disable_o)
    else $error("disable bit not set after reset");

endmodule
`default_nettype wire

// ===== testbench/supply_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// comparators, ring oscillator and crystal of the far side
// ------------------------------------------------------------------
module supply_model
  import pf_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic [1:0] level_i,
  input wire logic crystal_en_i,
  output var supply_t supply_o,
  output logic ring_tick_o,
  output logic crystal_ready_o
);
  logic [1:0] warm_reg = 2'h0;
  assign supply_o = {level_i != 2'h0, level_i[1], level_i == 2'h3};
  // ring period is two clocks, so long intervals still fit the run
  always @(posedge clk_i) begin
    ring_tick_o <= ~ring_tick_o;
  end
  initial ring_tick_o = 1'b0;
  always @(posedge clk_i) begin
    warm_reg <= !crystal_en_i ? 2'h0 : warm_reg + {1'b0, warm_reg != 2'h3};
  end
  assign crystal_ready_o = warm_reg == 2'h3;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// stop mode sequencer bench
// ------------------------------------------------------------------
module testbench;
  import pf_seq_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] lvl = 2'h3;
  logic stop_req_i = 1'b0;
  logic wake_irq_i = 1'b0;
  logic wake_irq_hi_prio_i = 1'b0;
  logic monitor_disable_wr_i = 1'b0;
  logic monitor_disable_i = 1'b0;
  logic pf_flag_clr_i = 1'b0;
  logic [1:0] interval_i = 2'h0;
  supply_t supply_i;
  logic ring_tick_i, crystal_ready_i, cpu_stopped_o, cpu_reset_o;
  logic regulator_en_o, crystal_en_o, monitor_en_o, sram_retain_o;
  logic pf_flag_o, stop_exit_o, vector_pf_o, resume_valid_o;
  logic stop_monitor_disable_o;
  logic [15:0] resume_addr_o;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  stop_mode_power_fail_sequencer #(.QUAL_CYCLES(2))
    stop_mode_power_fail_sequencer_i (
    .clk_i, .rstn_i, .supply_i, .stop_req_i, .wake_irq_i, .wake_irq_hi_prio_i,
    .monitor_disable_wr_i, .monitor_disable_i, .interval_i, .ring_tick_i,
    .crystal_ready_i, .pf_flag_clr_i, .cpu_stopped_o, .cpu_reset_o,
    .regulator_en_o, .crystal_en_o, .monitor_en_o, .sram_retain_o, .pf_flag_o,
    .stop_exit_o, .vector_pf_o, .resume_valid_o, .resume_addr_o,
    .stop_monitor_disable_o);
  supply_model supply_model_i (.clk_i, .level_i(lvl),
    .crystal_en_i(crystal_en_o), .supply_o(supply_i),
    .ring_tick_o(ring_tick_i), .crystal_ready_o(crystal_ready_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // whole run needs about 4.3k cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return resume_valid_o;
      1: return stop_exit_o;
      2: return cpu_reset_o;
      default: return crystal_en_o;
    endcase
  endfunction
  // bounded wait for an output, sampled at the falling edge
  task automatic wait_on(input int s, input int lim, output int k);
    for (k = 0; k < lim && pick(s) !== 1'b1; k++) @(negedge clk_i);
    chk("awaited output", 1'b1, pick(s));
  endtask
  task automatic go_stop();
    stop_req_i = 1'b1;
    @(negedge clk_i);
    stop_req_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic wr_dis(input logic v);
    monitor_disable_i = v;
    monitor_disable_wr_i = 1'b1;
    @(negedge clk_i);
    monitor_disable_wr_i = 1'b0;
  endtask
  task automatic restore();
    lvl = 2'h3;
    repeat (2) @(negedge clk_i);
    pf_flag_clr_i = 1'b1;
    @(negedge clk_i);
    pf_flag_clr_i = 1'b0;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("disable bit", 1'b1, stop_monitor_disable_o);
    rstn_i = 1'b1;
    wait_on(0, 40, n);
    chk("resume addr", 16'h8000, resume_addr_o);
    $display("test reset done");
  endtask
  task automatic t_dis(input logic p);
    wr_dis(1'b1);
    go_stop();
    lvl = 2'h2;
    repeat (8) @(negedge clk_i);
    chk("stopped", 1'b1, cpu_stopped_o);
    chk("monitor", 1'b0, monitor_en_o);
    chk("regulator", 1'b0, regulator_en_o);
    chk("pf flag", 1'b0, pf_flag_o);
    wake_irq_hi_prio_i = p;
    wake_irq_i = 1'b1;
    wait_on(1, 40, n);
    chk("pf flag", 1'b1, pf_flag_o);
    chk("vector pf", !p, vector_pf_o);
    wake_irq_i = 1'b0;
    restore();
    $display("test disabled wake done");
  endtask
  task automatic t_short_warn();
    wr_dis(1'b0);
    go_stop();
    lvl = 2'h2;
    @(negedge clk_i);
    lvl = 2'h3;
    repeat (6) @(negedge clk_i);
    chk("stopped", 1'b1, cpu_stopped_o);
    chk("crystal", 1'b0, crystal_en_o);
    chk("pf flag", 1'b0, pf_flag_o);
    lvl = 2'h2;
    wait_on(3, 20, n);
    chk("early exit", 1'b0, stop_exit_o);
    wait_on(1, 40, n);
    chk("regulator", 1'b1, regulator_en_o);
    chk("stopped", 1'b0, cpu_stopped_o);
    restore();
    $display("test short drop and warning done");
  endtask
  task automatic t_pfrst(input logic [1:0] ivl, input logic dis);
    interval_i = ivl;
    wr_dis(dis);
    go_stop();
    lvl = 2'h1;
    if (dis) begin
      repeat (6) @(negedge clk_i);
      chk("cpu reset", 1'b0, cpu_reset_o);
      wake_irq_i = 1'b1;
    end
    wait_on(2, 20, n);
    wake_irq_i = 1'b0;
    chk("regulator", 1'b0, regulator_en_o);
    chk("crystal", 1'b0, crystal_en_o);
    chk("sram retain", 1'b1, sram_retain_o);
    lvl = 2'h3;
    wait_on(0, 13000, n);
    chk("interval", 1'b1, ivl == 2'h0 ? n < 40 : n > 4000 && n < 4200);
    chk("resume addr", 16'h8000, resume_addr_o);
    restore();
    $display("test power fail reset done");
  endtask
  task automatic t_por();
    lvl = 2'h0;
    repeat (3) @(negedge clk_i);
    chk("cpu reset", 1'b1, cpu_reset_o);
    chk("monitor", 1'b0, monitor_en_o);
    chk("regulator", 1'b0, regulator_en_o);
    chk("crystal", 1'b0, crystal_en_o);
    lvl = 2'h3;
    wait_on(0, 60, n);
    $display("test poweron level done");
  endtask

  initial begin
    repeat (10) @(negedge clk_i);
    t_reset();
    t_dis(1'b0);
    t_dis(1'b1);
    t_short_warn();
    t_pfrst(IVL_2E11, 1'b0);
    t_pfrst(IVL_CONT, 1'b1);
    t_por();
    results();
  end
endmodule
`default_nettype wire
